// ==== fam_pkg.sv ====
`default_nettype none
package fam_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and flash bus timing
   localparam int unsigned CLK_MHZ    = 50;
   localparam int unsigned T_WP_NS    = 35;
   localparam int unsigned T_ACC_NS   = 70;
   localparam int unsigned WP_CYC     = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ACC_CYC    = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_CYC   = 3;
   localparam int unsigned RD_CYC     = ACC_CYC + SYNC_CYC;
   localparam int unsigned CNT_W      = 4;

   ////////////////////////////////////////////////////////////////////////////
   // flash side: widths, unlock addresses, command codes, status bits
   localparam int unsigned AW         = 22;
   localparam int unsigned DW         = 16;
   localparam logic [21:0] ADDR_UL1   = 22'h000555;
   localparam logic [21:0] ADDR_UL2   = 22'h0002AA;
   localparam logic [7:0]  CODE_UL1   = 8'hAA;
   localparam logic [7:0]  CODE_UL2   = 8'h55;
   localparam logic [7:0]  CODE_RESET = 8'hF0;
   localparam logic [7:0]  CODE_QEXIT = 8'hFF;
   localparam logic [7:0]  CODE_SREAD = 8'h70;
   localparam logic [7:0]  CODE_SCLR  = 8'h71;
   localparam logic [7:0]  CODE_XENT  = 8'h90;
   localparam logic [7:0]  CODE_XIT   = 8'h00;
   localparam logic [7:0]  CODE_PROG  = 8'hA0;
   localparam logic [7:0]  CODE_WBUF  = 8'h25;
   localparam logic [7:0]  CODE_CONF  = 8'h29;
   localparam int unsigned ST_READY   = 7;
   localparam int unsigned ST_PROT    = 2;
   localparam logic [7:0]  MAX_WORDS  = 8'h80;
   localparam int unsigned PAGE_BITS  = 7;

   ////////////////////////////////////////////////////////////////////////////
   // controller registers on apb
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_ADDR   = 8'h04;
   localparam logic [7:0]  OFS_WDATA  = 8'h08;
   localparam logic [7:0]  OFS_RDATA  = 8'h0C;
   localparam logic [7:0]  OFS_COUNT  = 8'h10;
   localparam logic [7:0]  OFS_STAT   = 8'h14;
   localparam logic [7:0]  OFS_ISTA   = 8'h18;
   localparam logic [7:0]  OFS_ICLR   = 8'h1C;
   localparam logic [7:0]  OFS_IEN    = 8'h20;
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_REFUSE = 1;
   localparam int unsigned IRQ_WORD   = 2;
   localparam int unsigned IRQ_W      = 3;
   localparam logic [7:0]  COUNT_RST  = 8'h01;

   typedef enum logic [3:0] {
      OP_READ      = 4'h0,
      OP_WRITE     = 4'h1,
      OP_ABORT_RST = 4'h2,
      OP_RESET     = 4'h3,
      OP_QEXIT     = 4'h4,
      OP_LR_PROG   = 4'h5,
      OP_LR_EXIT   = 4'h6,
      OP_SCLR      = 4'h7,
      OP_STATUS    = 4'h8,
      OP_SEC_WORD  = 4'h9,
      OP_SEC_BUF   = 4'hA,
      OP_SEC_EXIT  = 4'hB
   } fam_op_t;

   typedef enum logic [2:0] {
      K_END, K_WR, K_RD, K_STAT, K_POLL, K_CHK, K_LOAD
   } fam_kind_t;

   typedef enum logic [1:0] {A_UL1, A_UL2, A_USER} fam_asel_t;
   typedef enum logic [1:0] {D_CODE, D_USER, D_COUNT} fam_dsel_t;

   typedef struct packed {
      fam_kind_t  kind;
      fam_asel_t  asel;
      fam_dsel_t  dsel;
      logic [7:0] code;
   } fam_step_t;

   localparam fam_step_t S_END = '{K_END, A_USER, D_CODE, 8'h00};
   localparam fam_step_t S_UL1 = '{K_WR, A_UL1, D_CODE, CODE_UL1};
   localparam fam_step_t S_UL2 = '{K_WR, A_UL2, D_CODE, CODE_UL2};
   localparam fam_step_t S_DAT = '{K_WR, A_USER, D_USER, 8'h00};
   localparam fam_step_t S_PLL = '{K_POLL, A_UL1, D_CODE, CODE_SREAD};

   // micro-sequence of flash bus steps for each operation
   function automatic fam_step_t fam_step(fam_op_t op, logic [3:0] idx);
      fam_step_t seq [0:8];
      for (int i = 0; i < 9; i++) begin
         seq[i] = S_END;
      end
      case (op)
         OP_READ: seq[0] = '{K_RD, A_USER, D_CODE, 8'h00};
         OP_WRITE: seq[0] = S_DAT;
         OP_ABORT_RST: begin
            seq[0] = S_UL1;
            seq[1] = S_UL2;
            seq[2] = '{K_WR, A_UL1, D_CODE, CODE_RESET};
         end
         OP_RESET: seq[0] = '{K_WR, A_USER, D_CODE, CODE_RESET}; // [R5] [R6]
         OP_QEXIT: seq[0] = '{K_WR, A_USER, D_CODE, CODE_QEXIT}; // [R5]
         OP_LR_PROG: begin
            seq[0] = '{K_WR, A_USER, D_CODE, CODE_PROG};
            seq[1] = S_DAT;
            seq[2] = S_PLL;
         end
         OP_LR_EXIT: begin
            seq[0] = '{K_WR, A_USER, D_CODE, CODE_XENT};
            seq[1] = '{K_WR, A_USER, D_CODE, CODE_XIT}; // [R2]
         end
         OP_SCLR: seq[0] = '{K_WR, A_UL1, D_CODE, CODE_SCLR}; // [R2]
         OP_STATUS: seq[0] = '{K_STAT, A_UL1, D_CODE, CODE_SREAD};
         OP_SEC_WORD: begin
            seq[0] = '{K_CHK, A_UL1, D_CODE, CODE_SREAD};
            seq[1] = S_UL1;
            seq[2] = S_UL2;
            seq[3] = '{K_WR, A_UL1, D_CODE, CODE_PROG};
            seq[4] = S_DAT;
            seq[5] = S_PLL;
         end
         OP_SEC_BUF: begin
            seq[0] = '{K_CHK, A_UL1, D_CODE, CODE_SREAD};
            seq[1] = S_UL1;
            seq[2] = S_UL2;
            seq[3] = '{K_WR, A_USER, D_CODE, CODE_WBUF};
            seq[4] = '{K_WR, A_USER, D_COUNT, 8'h00};
            seq[5] = '{K_LOAD, A_USER, D_USER, 8'h00};
            seq[6] = '{K_WR, A_USER, D_CODE, CODE_CONF};
            seq[7] = S_PLL;
         end
         OP_SEC_EXIT: begin
            seq[0] = S_UL1;
            seq[1] = S_UL2;
            seq[2] = '{K_WR, A_UL1, D_CODE, CODE_XENT};
            seq[3] = '{K_WR, A_USER, D_CODE, CODE_XIT};
         end
         default: seq[0] = S_END;
      endcase
      return (idx < 4'h9) ? seq[idx] : S_END;
   endfunction

endpackage
`default_nettype wire

// ==== fam_host_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] After a buffer load fault the host recovers with AAh at 555h, 55h at 2AAh, then F0h at 555h.
// [R2] Lock-register mode is left by F0h or by 90h then 00h, and 71h at 555h clears status there.
// [R3] A lock-register program is A0h followed by one data write, after which the device goes back on its own.
// [R4] A hung lock-register program is released by an F0h reset write.
// [R5] Query mode is left by an F0h or an FFh write.
// [R6] Identification mode is left only by an F0h write.
// [R7] In secure-region mode 70h at 555h reads status and AAh at 555h starts unlocking.
// [R8] After 55h at 2AAh with the protect bit clear, A0h, 25h or 90h then 00h are accepted.
// [R9] A buffered load whose count passes 127 or whose sector differs aborts the device.
// [R10] Each data write inside the loaded page stores a word and counts down; outside the page it aborts.
// [R11] The confirm 29h at the same sector is given only after the count has run out.
// [R12] A secure program shows bit 7 low while busy and a hang is released by F0h.
// [R13] The host never issues the legacy resume codes.
// [R14] No secure-region program is issued once the protect bit is set.
// [R15] A secure program that ends cleanly returns the device to secure-region mode unaided.
// [R16] Writes that match no transition are ignored by the device.
module fam_host_ctrl (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pready,
   output var  logic        o_pslverr,
   output var  logic        o_irq,
   output var  logic [21:0] o_flash_addr,
   output var  logic [15:0] o_flash_dq,
   output var  logic        o_flash_dq_oe,
   input  wire logic [15:0] i_flash_dq,
   output var  logic        o_flash_ce_n,
   output var  logic        o_flash_oe_n,
   output var  logic        o_flash_we_n
);

   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_FETCH   = 3'b001,
      S_SETUP   = 3'b011,
      S_STROBE  = 3'b010,
      S_RECOVER = 3'b110,
      S_WAIT    = 3'b101
   } fam_seq_t;

   fam_seq_t                 st_reg,      st_next;
   fam_pkg::fam_op_t         op_reg,      op_next;
   logic [3:0]               idx_reg,     idx_next;
   logic                     ph_reg,      ph_next;
   logic                     rd_reg,      rd_next;
   logic [fam_pkg::CNT_W-1:0] cnt_reg,    cnt_next;
   logic [7:0]               word_reg,    word_next;
   logic [21:0]              addr_reg,    addr_next;
   logic [7:0]               count_reg,   count_next;
   logic [15:0]              wdata_reg,   wdata_next;
   logic                     wvalid_reg,  wvalid_next;
   logic [15:0]              rdata_reg,   rdata_next;
   logic                     refused_reg, refused_next;
   logic [fam_pkg::IRQ_W-1:0] ista_reg,   ista_next;
   logic [fam_pkg::IRQ_W-1:0] ien_reg,    ien_next;
   logic                     irq_reg,     irq_next;
   logic [21:0]              fa_reg,      fa_next;
   logic [15:0]              fdo_reg,     fdo_next;
   logic                     foe_reg,     foe_next;
   logic                     ce_n_reg,    ce_n_next;
   logic                     oe_n_reg,    oe_n_next;
   logic                     we_n_reg,    we_n_next;
   logic                     pready_reg,  pready_next;
   logic                     pslverr_reg, pslverr_next;
   logic [31:0]              prdata_reg,  prdata_next;
   logic [15:0]              dq_s1_reg, dq_s2_reg, dq_s3_reg;

   fam_pkg::fam_step_t       cur;
   logic                     setup_ph;
   logic                     wr_acc;
   logic                     busy;
   logic                     bad_buf;
   logic [fam_pkg::IRQ_W-1:0] ev_set;
   logic [fam_pkg::IRQ_W-1:0] ev_clr;

   assign cur      = fam_pkg::fam_step(op_reg, idx_reg);
   assign setup_ph = i_psel & ~i_penable;
   assign wr_acc   = i_psel & i_penable & pready_reg & i_pwrite;
   assign busy     = (st_reg != S_IDLE);
   // count of 1..128 words that stays inside one 128-word page
   assign bad_buf  = (count_reg == 8'h00) | (count_reg > fam_pkg::MAX_WORDS) |
                     (({1'b0, addr_reg[fam_pkg::PAGE_BITS-1:0]} + count_reg)
                      > fam_pkg::MAX_WORDS); // [R9] [R10]

   ////////////////////////////////////////////////////////////////////////////
   // register file, sequencer and flash pins
   always_comb begin
      st_next      = st_reg;
      op_next      = op_reg;
      idx_next     = idx_reg;
      ph_next      = ph_reg;
      rd_next      = rd_reg;
      cnt_next     = cnt_reg;
      word_next    = word_reg;
      addr_next    = addr_reg;
      count_next   = count_reg;
      wdata_next   = wdata_reg;
      wvalid_next  = wvalid_reg;
      rdata_next   = rdata_reg;
      refused_next = refused_reg;
      ien_next     = ien_reg;
      fa_next      = fa_reg;
      fdo_next     = fdo_reg;
      foe_next     = foe_reg;
      ce_n_next    = ce_n_reg;
      oe_n_next    = oe_n_reg;
      we_n_next    = we_n_reg;
      ev_set       = '0;
      ev_clr       = '0;
      pready_next  = setup_ph & ~pready_reg;
      pslverr_next = 1'b0;
      prdata_next  = 32'h0000_0000;

      // apb answer is prepared in the setup cycle, so no wait states
      if (setup_ph) begin
         unique case (i_paddr)
            fam_pkg::OFS_CTRL:  prdata_next[3:0]  = op_reg;
            fam_pkg::OFS_ADDR:  prdata_next[21:0] = addr_reg;
            fam_pkg::OFS_WDATA: prdata_next[15:0] = wdata_reg;
            fam_pkg::OFS_RDATA: prdata_next[15:0] = rdata_reg;
            fam_pkg::OFS_COUNT: prdata_next[7:0]  = count_reg;
            fam_pkg::OFS_STAT:  prdata_next[2:0]  =
                                   {refused_reg, wvalid_reg, busy};
            fam_pkg::OFS_ISTA:  prdata_next[2:0]  = ista_reg;
            fam_pkg::OFS_ICLR:  prdata_next       = 32'h0000_0000;
            fam_pkg::OFS_IEN:   prdata_next[2:0]  = ien_reg;
            default:            pslverr_next      = 1'b1;
         endcase
         // a new command while one runs would corrupt the sequence
         if (i_pwrite && busy && i_paddr == fam_pkg::OFS_CTRL) begin
            pslverr_next = 1'b1;
         end
      end

      if (wr_acc) begin
         unique case (i_paddr)
            fam_pkg::OFS_ADDR:  addr_next  = i_pwdata[21:0];
            fam_pkg::OFS_COUNT: count_next = i_pwdata[7:0];
            fam_pkg::OFS_ICLR:  ev_clr     = i_pwdata[2:0];
            fam_pkg::OFS_IEN:   ien_next   = i_pwdata[2:0];
            default: ;
         endcase
      end

      unique case (st_reg)
         S_IDLE: begin
            if (wr_acc && i_paddr == fam_pkg::OFS_CTRL) begin
               op_next   = fam_pkg::fam_op_t'(i_pwdata[3:0]);
               idx_next  = 4'h0;
               ph_next   = 1'b0;
               word_next = 8'h00;
               refused_next = 1'b0;
               // unknown codes, the legacy resume codes among them
               if (i_pwdata[3:0] > 4'hB) begin
                  refused_next = 1'b1; // [R13]
                  ev_set[fam_pkg::IRQ_REFUSE] = 1'b1;
               end else if (i_pwdata[3:0] == 4'hA && bad_buf) begin
                  refused_next = 1'b1; // [R9] [R10]
                  ev_set[fam_pkg::IRQ_REFUSE] = 1'b1;
               end else begin
                  st_next = S_FETCH;
               end
            end
         end
         S_FETCH: begin
            rd_next  = 1'b0;
            fdo_next = {8'h00, cur.code};
            fa_next  = (cur.asel == fam_pkg::A_UL1) ? fam_pkg::ADDR_UL1 :
                       (cur.asel == fam_pkg::A_UL2) ? fam_pkg::ADDR_UL2 :
                       addr_reg; // [R1] [R7] [R8]
            if (cur.dsel == fam_pkg::D_USER) begin
               fdo_next = wdata_reg; // [R3]
            end else if (cur.dsel == fam_pkg::D_COUNT) begin
               fdo_next = {8'h00, count_reg - 8'h01}; // [R9]
            end
            unique case (cur.kind)
               fam_pkg::K_END: begin
                  st_next = S_IDLE; // [R15]
                  ev_set[fam_pkg::IRQ_DONE] = 1'b1;
               end
               fam_pkg::K_WR: st_next = S_SETUP;
               fam_pkg::K_RD: begin
                  rd_next = 1'b1;
                  st_next = S_SETUP;
               end
               fam_pkg::K_STAT, fam_pkg::K_POLL, fam_pkg::K_CHK: begin
                  rd_next = ph_reg; // [R7] [R12]
                  st_next = S_SETUP;
               end
               fam_pkg::K_LOAD: begin
                  if (word_reg == count_reg) begin
                     idx_next = idx_reg + 4'h1; // [R11]
                  end else if (wvalid_reg) begin
                     // same page by the start check, so never aborts
                     fa_next     = addr_reg + {14'h0000, word_reg}; // [R10]
                     wvalid_next = 1'b0;
                     word_next   = word_reg + 8'h01;
                     st_next     = S_SETUP;
                  end else begin
                     ev_set[fam_pkg::IRQ_WORD] = 1'b1;
                     st_next = S_WAIT;
                  end
               end
               default: st_next = S_IDLE;
            endcase
            foe_next  = (st_next == S_SETUP) & ~rd_next;
            ce_n_next = ~(st_next == S_SETUP);
         end
         S_WAIT: begin
            if (wvalid_reg) begin
               st_next = S_FETCH;
            end
         end
         S_SETUP: begin
            st_next   = S_STROBE;
            oe_n_next = ~rd_reg;
            we_n_next = rd_reg;
            cnt_next  = rd_reg ? fam_pkg::CNT_W'(fam_pkg::RD_CYC - 1) :
                                 fam_pkg::CNT_W'(fam_pkg::WP_CYC - 1);
         end
         S_STROBE: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (!rd_reg || dq_s2_reg == dq_s3_reg) begin
               st_next    = S_RECOVER;
               oe_n_next  = 1'b1;
               we_n_next  = 1'b1;
               if (rd_reg) begin
                  rdata_next = dq_s3_reg;
               end
            end
         end
         S_RECOVER: begin
            st_next   = S_FETCH;
            ce_n_next = 1'b1;
            foe_next  = 1'b0;
            if (cur.kind == fam_pkg::K_WR || cur.kind == fam_pkg::K_RD) begin
               idx_next = idx_reg + 4'h1;
            end else if (cur.kind != fam_pkg::K_LOAD) begin
               ph_next = ~ph_reg;
               if (ph_reg) begin
                  if (cur.kind == fam_pkg::K_STAT) begin
                     idx_next = idx_reg + 4'h1;
                  end else if (cur.kind == fam_pkg::K_POLL) begin
                     // busy shows bit 7 low; a hang keeps polling until i_rst_n, as no new op is taken while busy
                     if (rdata_reg[fam_pkg::ST_READY]) begin
                        idx_next = idx_reg + 4'h1; // [R3] [R4] [R12]
                     end
                  end else if (rdata_reg[fam_pkg::ST_PROT]) begin
                     st_next      = S_IDLE; // [R14] [R8]
                     refused_next = 1'b1;
                     ev_set[fam_pkg::IRQ_REFUSE] = 1'b1;
                  end else begin
                     idx_next = idx_reg + 4'h1;
                  end
               end
            end
         end
         default: st_next = S_IDLE;
      endcase

      // a fresh word written in the cycle it is consumed stays pending
      if (wr_acc && i_paddr == fam_pkg::OFS_WDATA) begin
         wdata_next  = i_pwdata[15:0];
         wvalid_next = 1'b1;
      end
      ista_next = ev_set | (ista_reg & ~ev_clr);
      irq_next  = |(ista_next & ien_next);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg      <= S_IDLE;
         op_reg      <= fam_pkg::OP_READ;
         idx_reg     <= 4'h0;
         ph_reg      <= 1'b0;
         rd_reg      <= 1'b0;
         cnt_reg     <= '0;
         word_reg    <= 8'h00;
         addr_reg    <= 22'h000000;
         count_reg   <= fam_pkg::COUNT_RST;
         wdata_reg   <= 16'h0000;
         wvalid_reg  <= 1'b0;
         rdata_reg   <= 16'h0000;
         refused_reg <= 1'b0;
         ista_reg    <= '0;
         ien_reg     <= '0;
         irq_reg     <= 1'b0;
         fa_reg      <= 22'h000000;
         fdo_reg     <= 16'h0000;
         foe_reg     <= 1'b0;
         ce_n_reg    <= 1'b1;
         oe_n_reg    <= 1'b1;
         we_n_reg    <= 1'b1;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         dq_s1_reg   <= 16'h0000;
         dq_s2_reg   <= 16'h0000;
         dq_s3_reg   <= 16'h0000;
      end else begin
         st_reg      <= st_next;
         op_reg      <= op_next;
         idx_reg     <= idx_next;
         ph_reg      <= ph_next;
         rd_reg      <= rd_next;
         cnt_reg     <= cnt_next;
         word_reg    <= word_next;
         addr_reg    <= addr_next;
         count_reg   <= count_next;
         wdata_reg   <= wdata_next;
         wvalid_reg  <= wvalid_next;
         rdata_reg   <= rdata_next;
         refused_reg <= refused_next;
         ista_reg    <= ista_next;
         ien_reg     <= ien_next;
         irq_reg     <= irq_next;
         fa_reg      <= fa_next;
         fdo_reg     <= fdo_next;
         foe_reg     <= foe_next;
         ce_n_reg    <= ce_n_next;
         oe_n_reg    <= oe_n_next;
         we_n_reg    <= we_n_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
         dq_s1_reg   <= i_flash_dq;
         dq_s2_reg   <= dq_s1_reg;
         dq_s3_reg   <= dq_s2_reg;
      end
   end

   assign o_prdata      = prdata_reg;
   assign o_pready      = pready_reg;
   assign o_pslverr     = pslverr_reg;
   assign o_irq         = irq_reg;
   assign o_flash_addr  = fa_reg;
   assign o_flash_dq    = fdo_reg;
   assign o_flash_dq_oe = foe_reg;
   assign o_flash_ce_n  = ce_n_reg;
   assign o_flash_oe_n  = oe_n_reg;
   assign o_flash_we_n  = we_n_reg;

endmodule
`default_nettype wire

// ==== fam_host_ctrl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module fam_host_ctrl_asserts (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic [7:0]  i_paddr,
   input  wire logic        o_pready,
   input  wire logic        o_pslverr,
   input  wire logic [21:0] o_flash_addr,
   input  wire logic        o_flash_dq_oe,
   input  wire logic        o_flash_ce_n,
   input  wire logic        o_flash_oe_n,
   input  wire logic        o_flash_we_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // the strobe must stay low two cycles to meet the write pulse width
   sequence s_we_hold;
      !o_flash_we_n ##1 o_flash_we_n;
   endsequence
   a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (o_pready && i_paddr > 8'h20 |-> o_pslverr)
      else $error("unmapped access without error");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("error outside access cycle");
   a_we_width: assert property ($fell(o_flash_we_n) |=> s_we_hold)
      else $error("write pulse width wrong");
   a_we_framed: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe && o_flash_oe_n)
      else $error("write strobe without select or data");
   a_read_width: assert property ($fell(o_flash_oe_n) |-> !o_flash_oe_n[*4] ##[1:40] o_flash_oe_n)
      else $error("read strobe width wrong");
   a_addr_steady: assert property (!o_flash_ce_n && $past(!o_flash_ce_n) |-> $stable(o_flash_addr))
      else $error("address moved inside a cycle");
   a_idle_quiet: assert property (o_flash_ce_n |-> o_flash_we_n && o_flash_oe_n)
      else $error("strobe active while deselected");
endmodule
bind fam_host_ctrl fam_host_ctrl_asserts fam_host_ctrl_asserts_inst (.*);
`default_nettype wire

// ==== fam_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fam_flash_model (
   input  wire logic        i_ce_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic [21:0] i_addr,
   input  wire logic [15:0] i_dq,
   input  wire logic        i_prot,
   output var  logic [15:0] o_dq
);
   int          st = 1;
   int          wc = 0;
   int          busy = 0;
   int          progs = 0;
   logic [21:0] sa = 22'h0;
   logic [7:0]  d;
   logic [15:0] stat;
   // states: 1 secure, 2/3 unlock, 4 word setup, 5/6 buffer, 7 busy,
   // 8 exit pending, 9..11 abort recovery
   always @(posedge i_we_n) if (!i_ce_n) begin
      d = i_dq[7:0];
      case (st)
         1: if (i_addr == 22'h000555 && d == 8'hAA) st = 2;
         2: if (i_addr == 22'h0002AA && d == 8'h55) st = 3;
         3: if (i_addr == 22'h000555 && d == 8'hA0 && !i_prot) st = 4;
            else if (d == 8'h25 && !i_prot) begin
               st = 5;
               sa = i_addr;
            end else if (i_addr == 22'h000555 && d == 8'h90) st = 8;
         4: begin st = 7; busy = 2; progs++; end
         5: if (d > 8'h7F || i_addr[21:15] != sa[21:15]) st = 9;
            else begin st = 6; wc = d; end
         6: if (wc < 0 && d == 8'h29 && i_addr[21:15] == sa[21:15]) begin
               st = 7; busy = 2; progs++;
            end else if (wc >= 0 && i_addr[21:7] == sa[21:7]) wc--;
            else st = 9;
         8: if (d == 8'h00 || d == 8'hF0) st = 1;
         9: if (i_addr == 22'h000555 && d == 8'hAA) st = 10;
         10: if (i_addr == 22'h0002AA && d == 8'h55) st = 11;
         11: if (i_addr == 22'h000555 && d == 8'hF0) st = 1;
         default: ;
      endcase
   end
   // ready stays low for two status reads, then the mode comes back
   always @(posedge i_oe_n) if (busy > 0) busy--; else if (st == 7) st = 1;
   assign stat = {8'h00, busy == 0, 4'h0, i_prot, 2'b00};
   // a released bus shows the inverse so stale data cannot pass
   assign o_dq = (!i_ce_n && !i_oe_n) ? stat : ~stat;
endmodule
`default_nettype wire

// ==== fam_host_ctrl_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module fam_host_ctrl_bench;
   logic        i_clk = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, junk;
   logic        pready, pslverr, irq, dq_oe, ce_n, oe_n, we_n, last_err;
   logic        prot = 0;
   logic [21:0] faddr;
   logic [15:0] dq_out, dq_in;
   int          error_cnt = 0, compares = 0;

   fam_host_ctrl fam_host_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_irq(irq), .o_flash_addr(faddr),
      .o_flash_dq(dq_out), .o_flash_dq_oe(dq_oe), .i_flash_dq(dq_in),
      .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n));
   fam_flash_model fam_flash_model_inst (.i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_addr(faddr), .i_dq(dq_out), .i_prot(prot),
      .o_dq(dq_in));

   initial forever #10 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge i_clk);
      penable <= 1;
      // only the watchdog ends a wait for the answer
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, junk);
   endtask
   // polls the sticky flags; hands over a word when one is wanted, at most words of them in all
   task automatic run(input logic [3:0] op, input int words,
                      output logic [31:0] st);
      wr(fam_pkg::OFS_ICLR, 32'h7);
      wr(fam_pkg::OFS_CTRL, {28'h0, op});
      for (int i = 0; i < 300; i++) begin
         apb(1'b0, fam_pkg::OFS_ISTA, 32'h0, st);
         if (st[2] && words > 0) begin
            wr(fam_pkg::OFS_ICLR, 32'h4);
            wr(fam_pkg::OFS_WDATA, 32'h1230 + i);
            words--;
         end
         if (st[1:0] != 2'b00) break;
      end
      st = st & 32'h3;
   endtask
   task automatic t_regs;
      apb(1'b0, fam_pkg::OFS_COUNT, 32'h0, junk);
      check("count reset", 32'h1, junk);
      apb(1'b0, 8'h40, 32'h0, junk);
      check("unmapped error", 32'h1, {31'h0, last_err});
      $display("t_regs done");
   endtask
   task automatic t_word;
      logic [31:0] v;
      wr(fam_pkg::OFS_IEN, 32'h1);
      wr(fam_pkg::OFS_ADDR, 32'h10);
      wr(fam_pkg::OFS_WDATA, 32'hBEEF);
      run(4'h9, 0, v);
      check("word done", 32'h1, v);
      check("word programs", 32'h1, fam_flash_model_inst.progs);
      check("word mode", 32'h1, fam_flash_model_inst.st);
      check("irq raised", 32'h1, {31'h0, irq});
      wr(fam_pkg::OFS_ICLR, 32'h1);
      @(posedge i_clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      $display("t_word done");
   endtask
   task automatic t_buf;
      logic [31:0] v;
      wr(fam_pkg::OFS_COUNT, 32'h2);
      wr(fam_pkg::OFS_ADDR, 32'h100);
      wr(fam_pkg::OFS_WDATA, 32'h1111);
      run(4'hA, 1, v);
      check("buffer done", 32'h1, v);
      check("buffer programs", 32'h2, fam_flash_model_inst.progs);
      check("buffer mode", 32'h1, fam_flash_model_inst.st);
      $display("t_buf done");
   endtask
   task automatic t_fail;
      logic [31:0] v;
      wr(fam_pkg::OFS_COUNT, 32'h0);
      run(4'hA, 0, v);
      check("zero count", 32'h2, v);
      prot <= 1;
      run(4'h9, 0, v);
      check("protected", 32'h2, v);
      check("no program", 32'h2, fam_flash_model_inst.progs);
      check("irq masked", 32'h0, {31'h0, irq});
      prot <= 0;
      $display("t_fail done");
   endtask
   task automatic t_abort;
      logic [31:0] v;
      fam_flash_model_inst.st = 9;
      run(4'h2, 0, v);
      check("abort done", 32'h1, v);
      check("abort mode", 32'h1, fam_flash_model_inst.st);
      $display("t_abort done");
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1;
      t_regs;
      t_word;
      t_buf;
      t_fail;
      t_abort;
      give_verdict;
   end
   // all tests need well under a third of this span
   initial begin
      #400000;
      error_cnt++;
      give_verdict;
   end
endmodule
`default_nettype wire
